// >>> bench/serial_program_port_readback_tb.sv
// self-checking bench for the programming port read-back block
`timescale 1ns/1ps
`default_nettype none
module serial_program_port_readback_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic progClk, progRst, progDataIn, progDataOut, progDataOe;
    logic [7:0]  codeInitByte = 8'h00;
    logic        codeInitWe = 1'b0;
    logic [12:0] codeInitAddr = 13'h0000;
    logic [5:0]  codeProtN;
    logic [6:0]  writeProtN;
    logic        readDone;
    logic [7:0]  mem [0:8191];
    int mismatches = 0;
    int checks = 0;
    int doneCnt = 0;
    int nRd = 0;
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (readDone === 1'b1) doneCnt++;
    sprb_port u_sprb_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .progClk(progClk), .progRst(progRst), .progDataIn(progDataIn),
        .progDataOut(progDataOut), .progDataOe(progDataOe),
        .codeInitByte(codeInitByte), .codeInitWe(codeInitWe),
        .codeInitAddr(codeInitAddr), .codeProtN(codeProtN),
        .writeProtN(writeProtN), .readDone(readDone));
    sprb_prog_model u_sprb_prog_model (.progClk(progClk),
        .progRst(progRst), .progDataIn(progDataIn),
        .progDataOut(progDataOut), .progDataOe(progDataOe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // expected byte at a pointer value
    function automatic logic [7:0] expByte(input logic [21:0] a);
        if (a <= sprb_pkg::CODE_LAST) return mem[a[12:0]];
        if (a == sprb_pkg::DEVID_LOW_ADDR)
            return {sprb_pkg::DEVID_VARIANT, sprb_pkg::DEVID_REV};
        if (a == sprb_pkg::DEVID_HI_ADDR) return sprb_pkg::DEVID_HIGH_VAL;
        return sprb_pkg::CFG_RESET;
    endfunction
    // pointer after one read; code space wraps to zero
    function automatic logic [21:0] nextPtr(input logic [21:0] a);
        return (a == sprb_pkg::CODE_LAST) ? 22'h000000 : a + 22'h000001;
    endfunction
    task automatic core(input logic [7:0] op, input logic [7:0] arg);
        logic [7:0] d;
        u_sprb_prog_model.frame(sprb_pkg::CMD_CORE, {op, arg}, d);
    endtask
    // immediate load then move, per pointer byte
    task automatic setPtr(input logic [21:0] a);
        core(sprb_pkg::OP_MOVLW, {2'h0, a[21:16]});
        core(sprb_pkg::OP_MOVWF, sprb_pkg::RAM_PTR_UPPER);
        core(sprb_pkg::OP_MOVLW, a[15:8]);
        core(sprb_pkg::OP_MOVWF, sprb_pkg::RAM_PTR_HIGH);
        core(sprb_pkg::OP_MOVLW, a[7:0]);
        core(sprb_pkg::OP_MOVWF, sprb_pkg::RAM_PTR_LOW);
    endtask
    initial begin
        #400_000;
        mismatches++;
        summarize();
    end
    initial begin
        logic [7:0]  d, d2, e;
        logic [21:0] a;
        int          n;
        logic [15:0] w;
        void'($urandom(6552));
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // preload code memory with random bytes
        for (int i = 0; i < 8192; i++) begin
            @(posedge ref_clk);
            mem[i] = 8'($urandom);
            codeInitWe <= 1'b1;
            codeInitAddr <= 13'(i);
            codeInitByte <= mem[i];
        end
        @(posedge ref_clk);
        codeInitWe <= 1'b0;
        u_sprb_prog_model.linkReset();
        check(16'(codeProtN), 16'h003F);
        check(16'(writeProtN), 16'h007F);
        // refused command, then two back-to-back reads merged into a word
        for (int k = 0; k < 8; k++) begin
            a = 22'($urandom_range(8190));
            if (k == 4) a = sprb_pkg::CODE_LAST;
            if (k == 5) a = sprb_pkg::CFG5L_ADDR;
            if (k == 6) a = sprb_pkg::CFG6L_ADDR;
            if (k == 7) a = sprb_pkg::DEVID_LOW_ADDR;
            n = u_sprb_prog_model.oeSeen;
            u_sprb_prog_model.frame(4'hF, 16'($urandom), d);
            check(16'(u_sprb_prog_model.oeSeen - n), 16'h0000);
            setPtr(a);
            u_sprb_prog_model.frame(sprb_pkg::CMD_TABLE_READ, 16'h0000, d);
            u_sprb_prog_model.frame(sprb_pkg::CMD_TABLE_READ, 16'h0000, d2);
            nRd += 2;
            w = {expByte(nextPtr(a)), expByte(a)};
            check({d2, d}, w);
            if (k == 5 || k == 6) check(16'(d), 16'(expByte(a)));
        end
        // id bytes: pointer reloaded, first read thrown away and repeated
        setPtr(sprb_pkg::ID_BASE);
        u_sprb_prog_model.frame(sprb_pkg::CMD_TABLE_READ, 16'h0000, d);
        setPtr(sprb_pkg::ID_BASE);
        u_sprb_prog_model.frame(sprb_pkg::CMD_TABLE_READ, 16'h0000, d);
        nRd += 2;
        check(16'(d), 16'(expByte(sprb_pkg::ID_BASE)));
        // eeprom byte through data latch, table latch and shift-out
        for (int k = 0; k < 4; k++) begin
            e = (k == 0) ? 8'hFF : 8'($urandom);
            core(sprb_pkg::OP_BCF | 8'h0E, sprb_pkg::RAM_MEM_CTRL);
            core(sprb_pkg::OP_BCF | 8'h0C, sprb_pkg::RAM_MEM_CTRL);
            core(sprb_pkg::OP_MOVLW, e);
            core(sprb_pkg::OP_MOVWF, sprb_pkg::RAM_EE_ADDR_LO);
            core(sprb_pkg::OP_MOVLW, 8'h00);
            core(sprb_pkg::OP_MOVWF, sprb_pkg::RAM_EE_ADDR_HI);
            core(sprb_pkg::OP_BSF, sprb_pkg::RAM_MEM_CTRL);
            core(sprb_pkg::OP_MOVF, sprb_pkg::RAM_EE_DATA);
            core(sprb_pkg::OP_MOVWF, sprb_pkg::RAM_TAB_LATCH);
            core(8'h00, 8'h00);
            u_sprb_prog_model.frame(sprb_pkg::CMD_SHIFT_OUT, 16'h0000, d);
            check(16'(d), 16'(e));
        end
        repeat (20) @(posedge ref_clk);
        check(16'(doneCnt), 16'(nRd));
        summarize();
    end
endmodule // serial_program_port_readback_tb
`default_nettype wire

// >>> bench/sprb_prog_model.sv
// programmer model: makes the link clock and drives the data line
`timescale 1ns/1ps
`default_nettype none
module sprb_prog_model (
    // link outputs
    output logic      progClk,
    output logic      progRst,
    output logic      progDataIn,
    // device drive
    input  wire logic progDataOut,
    input  wire logic progDataOe
);
    logic drvOn = 1'b0;
    logic drvBit = 1'b0;
    logic junk = 1'b0;
    int   oeSeen = 0;
    initial begin
        progClk = 1'b0;
        progRst = 1'b0;
    end
    // a released line keeps toggling so a stale bit never looks valid
    always #40 junk = ~junk;
    assign progDataIn = progDataOe ? progDataOut : (drvOn ? drvBit : junk);
    always @(posedge progDataOe) oeSeen++;
    // one clock: data set after the fall, sampled just before the next fall
    task automatic pulse(input logic b, output logic s);
        #10 drvBit = b;
        #30 progClk = 1'b1;
        #40 s = progDataIn;
        progClk = 1'b0;
    endtask
    // one command frame; read data comes back lsb first
    task automatic frame(input logic [3:0] c, input logic [15:0] op,
                         output logic [7:0] rd);
        logic s;
        drvOn = 1'b1;
        for (int i = 0; i < 4; i++) pulse(c[i], s);
        for (int i = 0; i < 8; i++) pulse(op[i], s);
        if (c == sprb_pkg::CMD_TABLE_READ ||
            c == sprb_pkg::CMD_SHIFT_OUT) begin
            drvOn = 1'b0;
            #100; // clock held low for the turnaround
            for (int i = 0; i < 8; i++) begin
                pulse(1'b0, s);
                rd[i] = s;
            end
        end else begin
            for (int i = 8; i < 16; i++) pulse(op[i], s);
        end
        #40;
    endtask
    // link reset across two falling edges
    task automatic linkReset();
        logic s;
        progRst = 1'b1;
        pulse(1'b0, s);
        pulse(1'b0, s);
        #10 progRst = 1'b0;
    endtask
endmodule // sprb_prog_model
`default_nettype wire

// >>> design/sprb_port.sv
// read-back side of the serial programming port
`timescale 1ns/1ps
`default_nettype none
module sprb_port #(
    parameter int CODE_WORDS = 8192,
    parameter int EE_BYTES   = 256
) (
    // system
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // link clock from the programmer
    input  wire logic progClk,
    input  wire logic progRst,
    // two-way data line
    input  wire logic progDataIn,
    output logic      progDataOut,
    output logic      progDataOe,
    // nonvolatile contents, loaded at reset by the system side
    input  wire logic [7:0] codeInitByte,
    input  wire logic       codeInitWe,
    input  wire logic [12:0] codeInitAddr,
    // status seen by the core
    output logic [5:0] codeProtN,
    output logic [6:0] writeProtN,
    output logic       readDone
);
    // link-domain state, all on progClk
    typedef enum logic [2:0] {
        ST_CMD  = 3'b001,
        ST_OPER = 3'b010,
        ST_OUT  = 3'b100
    } sprb_state_t;

    sprb_state_t stateReg, stateNext;
    logic [4:0]  cntReg, cntNext;
    logic [3:0]  cmdReg, cmdNext;
    logic [15:0] shReg, shNext;
    logic [7:0]  outReg, outNext;
    logic [21:0] ptrReg, ptrNext;
    logic [7:0]  wregReg, wregNext;
    logic [7:0]  tabLatchReg, tabLatchNext;
    logic [7:0]  eeAddrLoReg, eeAddrLoNext;
    logic [7:0]  eeAddrHiReg, eeAddrHiNext;
    logic [7:0]  eeDataReg, eeDataNext;
    logic [7:0]  memCtrlReg, memCtrlNext;
    logic [7:0]  cp5lReg, cp5hReg, wp6lReg, wp6hReg;
    logic        doneTogReg, doneTogNext;
    logic        driveReg;
    logic [7:0]  codeMem [CODE_WORDS];
    logic [7:0]  eeMem [EE_BYTES];
    logic [7:0]  fetchByte;
    logic [15:0] word;

    // falling-edge sampling of data, lsb first
    always_comb begin
        stateNext    = stateReg;
        cntNext      = cntReg + 5'h01;
        cmdNext      = cmdReg;
        shNext       = shReg;
        outNext      = outReg;
        ptrNext      = ptrReg;
        wregNext     = wregReg;
        tabLatchNext = tabLatchReg;
        eeAddrLoNext = eeAddrLoReg;
        eeAddrHiNext = eeAddrHiReg;
        eeDataNext   = eeDataReg;
        memCtrlNext  = memCtrlReg;
        doneTogNext  = doneTogReg;
        word         = {progDataIn, shReg[15:1]};
        case (stateReg)
            ST_CMD: begin
                cmdNext = {progDataIn, cmdReg[3:1]};
                if (cntReg == 5'(sprb_pkg::CMD_BITS - 1)) begin
                    cntNext   = 5'h00;
                    stateNext = ST_OPER;
                end
            end
            ST_OPER: begin
                shNext = word;
                if (cntReg == 5'(sprb_pkg::FETCH_BITS - 1) &&
                    cmdReg == sprb_pkg::CMD_TABLE_READ) begin
                    outNext     = fetchByte;
                    doneTogNext = ~doneTogReg;
                    // wrap past last code address
                    ptrNext = (ptrReg == sprb_pkg::CODE_LAST) ?
                              22'h000000 : ptrReg + 22'h000001;
                    stateNext = ST_OUT;
                end else if (cntReg == 5'(sprb_pkg::FETCH_BITS - 1) &&
                    cmdReg == sprb_pkg::CMD_SHIFT_OUT) begin
                    outNext   = tabLatchReg;
                    stateNext = ST_OUT;
                end else if (cntReg == 5'(sprb_pkg::OPER_BITS - 1)) begin
                    cntNext   = 5'h00;
                    stateNext = ST_CMD;
                    if (cmdReg == sprb_pkg::CMD_CORE) begin
                        case (word[15:8])
                            sprb_pkg::OP_MOVLW: wregNext = word[7:0];
                            sprb_pkg::OP_MOVF: begin
                                if (word[7:0] == sprb_pkg::RAM_EE_DATA)
                                    wregNext = eeDataReg;
                                else if (word[7:0] == sprb_pkg::RAM_TAB_LATCH)
                                    wregNext = tabLatchReg;
                                else if (word[7:0] == sprb_pkg::RAM_MEM_CTRL)
                                    wregNext = memCtrlReg;
                            end
                            sprb_pkg::OP_MOVWF: begin
                                case (word[7:0])
                                    sprb_pkg::RAM_PTR_UPPER:
                                        ptrNext[21:16] = wregReg[5:0];
                                    sprb_pkg::RAM_PTR_HIGH:
                                        ptrNext[15:8] = wregReg;
                                    sprb_pkg::RAM_PTR_LOW:
                                        ptrNext[7:0] = wregReg;
                                    sprb_pkg::RAM_TAB_LATCH:
                                        tabLatchNext = wregReg;
                                    sprb_pkg::RAM_EE_ADDR_LO:
                                        eeAddrLoNext = wregReg;
                                    sprb_pkg::RAM_EE_ADDR_HI:
                                        eeAddrHiNext = wregReg;
                                    sprb_pkg::RAM_EE_DATA:
                                        eeDataNext = wregReg;
                                    default: ;
                                endcase
                            end
                            default: begin
                                // bit set/clear on the control register
                                if (word[7:0] == sprb_pkg::RAM_MEM_CTRL &&
                                    (word[15:12] == 4'h8 ||
                                     word[15:12] == 4'h9))
                                    memCtrlNext[word[11:9]] = ~word[12];
                            end
                        endcase
                    end
                end
            end
            ST_OUT: begin
                outNext = {1'b0, outReg[7:1]}; // lsb first
                if (cntReg == 5'(sprb_pkg::OPER_BITS - 1)) begin
                    cntNext   = 5'h00;
                    stateNext = ST_CMD;
                end
            end
            default: begin
                stateNext = ST_CMD;
                cntNext   = 5'h00;
            end
        endcase
        // read strobe loads the eeprom latch and self-clears
        if (memCtrlReg[sprb_pkg::CTRL_RD_BIT]) begin
            eeDataNext = eeMem[eeAddrLoReg];
            memCtrlNext[sprb_pkg::CTRL_RD_BIT] = 1'b0;
        end
    end

    // byte fetch across the whole pointer space
    always_comb begin
        if (ptrReg <= sprb_pkg::CODE_LAST)
            fetchByte = codeMem[ptrReg[12:0]];
        else if (ptrReg == sprb_pkg::DEVID_HI_ADDR)
            fetchByte = sprb_pkg::DEVID_HIGH_VAL;
        else if (ptrReg == sprb_pkg::DEVID_LOW_ADDR)
            fetchByte = {sprb_pkg::DEVID_VARIANT, sprb_pkg::DEVID_REV};
        else if (ptrReg == sprb_pkg::CFG5L_ADDR)
            fetchByte = cp5lReg;
        else if (ptrReg == sprb_pkg::CFG5H_ADDR)
            fetchByte = cp5hReg;
        else if (ptrReg == sprb_pkg::CFG6L_ADDR)
            fetchByte = wp6lReg;
        else if (ptrReg == sprb_pkg::CFG6H_ADDR)
            fetchByte = wp6hReg;
        else
            fetchByte = 8'hFF;
    end

    // link state registers sample on the falling clock edge
    always_ff @(negedge progClk) begin
        if (progRst) begin
            stateReg    <= ST_CMD;
            cntReg      <= 5'h00;
            cmdReg      <= 4'h0;
            shReg       <= 16'h0000;
            outReg      <= 8'h00;
            ptrReg      <= 22'h000000;
            wregReg     <= 8'h00;
            tabLatchReg <= 8'h00;
            eeAddrLoReg <= 8'h00;
            eeAddrHiReg <= 8'h00;
            eeDataReg   <= 8'h00;
            memCtrlReg  <= 8'h00;
            doneTogReg  <= 1'b0;
        end else begin
            stateReg    <= stateNext;
            cntReg      <= cntNext;
            cmdReg      <= cmdNext;
            shReg       <= shNext;
            outReg      <= outNext;
            ptrReg      <= ptrNext;
            wregReg     <= wregNext;
            tabLatchReg <= tabLatchNext;
            eeAddrLoReg <= eeAddrLoNext;
            eeAddrHiReg <= eeAddrHiNext;
            eeDataReg   <= eeDataNext;
            memCtrlReg  <= memCtrlNext;
            doneTogReg  <= doneTogNext;
        end
    end

    // output enable changes after the rising edge, giving the turnaround
    always_ff @(posedge progClk) begin
        if (progRst)
            driveReg <= 1'b0;
        else
            driveReg <= (stateReg == ST_OUT);
    end

    assign progDataOut = outReg[0];
    assign progDataOe  = driveReg;

    // protection bytes erased to all ones; no write path in this block
    assign cp5lReg = sprb_pkg::CFG_RESET;
    assign cp5hReg = sprb_pkg::CFG_RESET;
    assign wp6lReg = sprb_pkg::CFG_RESET;
    assign wp6hReg = sprb_pkg::CFG_RESET;

    // storage loaded by the system; eeprom contents fixed, each byte holding its own address
    always_ff @(posedge ref_clk) begin
        if (codeInitWe)
            codeMem[codeInitAddr] <= codeInitByte;
    end
    for (genvar i = 0; i < EE_BYTES; i++) begin : g_ee
        assign eeMem[i] = 8'(i);
    end

    // crossing of the read-done toggle and protection levels into ref_clk
    logic [2:0] doneSyncReg;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            doneSyncReg <= 3'b000;
            codeProtN   <= 6'h3F;
            writeProtN  <= 7'h7F;
        end else begin
            doneSyncReg <= {doneSyncReg[1:0], doneTogReg};
            codeProtN   <= {cp5hReg[7:6], cp5lReg[3:0]};
            writeProtN  <= {wp6hReg[7:5], wp6lReg[3:0]};
        end
    end
    assign readDone = doneSyncReg[2] ^ doneSyncReg[1];

    // pointer advance and wrap after each table read
    a_ptr_incr: assert property (
        @(negedge progClk) disable iff (progRst)
        (stateReg == ST_OPER && cmdReg == sprb_pkg::CMD_TABLE_READ &&
         cntReg == 5'd7 && ptrReg != sprb_pkg::CODE_LAST)
        |=> ptrReg == $past(ptrReg) + 22'd1)
        else $error("pointer did not advance");
    a_ptr_wrap: assert property (
        @(negedge progClk) disable iff (progRst)
        (stateReg == ST_OPER && cmdReg == sprb_pkg::CMD_TABLE_READ &&
         cntReg == 5'd7 && ptrReg == sprb_pkg::CODE_LAST)
        |=> ptrReg == 22'd0)
        else $error("pointer did not wrap");
    // frame phase lengths
    a_out_len: assert property (
        @(negedge progClk) disable iff (progRst)
        $rose(stateReg == ST_OUT) |-> (stateReg == ST_OUT) [*8])
        else $error("output phase not eight bits");
    a_cmd_len: assert property (
        @(negedge progClk) disable iff (progRst)
        $rose(stateReg == ST_CMD) |-> (stateReg == ST_CMD) [*4])
        else $error("command phase not four bits");
    // line is driven only in the output phase, and from its first bit on
    a_oe_state: assert property (
        @(negedge progClk) disable iff (progRst)
        progDataOe |-> stateReg == ST_OUT)
        else $error("data line driven outside output phase");
    a_oe_follow: assert property (
        @(negedge progClk) disable iff (progRst)
        $rose(stateReg == ST_OUT) |-> progDataOe)
        else $error("data line not driven in output phase");
    // read strobe is a one-shot, so a stale strobe never reloads the latch
    a_rd_clear: assert property (
        @(negedge progClk) disable iff (progRst)
        memCtrlReg[sprb_pkg::CTRL_RD_BIT] |=>
        !memCtrlReg[sprb_pkg::CTRL_RD_BIT])
        else $error("read strobe did not clear");
    a_done_pulse: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        readDone |=> !readDone)
        else $error("read-done pulse longer than one cycle");
    c_table_read: cover property (@(negedge progClk)
        stateReg == ST_OUT && cmdReg == sprb_pkg::CMD_TABLE_READ);
    c_shift_out: cover property (@(negedge progClk)
        stateReg == ST_OUT && cmdReg == sprb_pkg::CMD_SHIFT_OUT);
    c_wrap: cover property (@(negedge progClk)
        ptrReg == sprb_pkg::CODE_LAST ##1 ptrReg == 22'd0);
endmodule // sprb_port
`default_nettype wire

// >>> pkg/sprb_pkg.sv
// constants for the serial programming port read-back block
// Operation
// - command 1001 reads one byte at the 22-bit table pointer
// - memory access happens during the first 8 operand clocks
// - device drives the fetched byte lsb first during the last 8 clocks
// - each table read advances the table pointer by one
// - table read works across the whole 22-bit pointer space
// - post-increment past last code address wraps pointer to zero
// - eeprom read: address pair, read strobe in control reg, result latched; the read here uses the low address byte only
// - command 0010 shifts the holding register out during operand
// - holding shift-out: low byte undefined, high byte carries data
// - two read-only id bytes; low byte top 3 bits variant, rest revision
// - four code blocks and boot block each have code-protect bit, 0 protects
// - separate eeprom code-protect bit, 0 protects
// - blocks, boot and eeprom each have write-protect bit, 0 blocks writes
// - config write-protect bit at 0 blocks configuration writes
// - sample input on falling edge, drive output after rising edge
package sprb_pkg;
    localparam logic [3:0]  CMD_CORE       = 4'h0;
    localparam logic [3:0]  CMD_SHIFT_OUT  = 4'h2;
    localparam logic [3:0]  CMD_TABLE_READ = 4'h9;
    localparam int          CMD_BITS       = 4;
    localparam int          OPER_BITS      = 16;
    localparam int          FETCH_BITS     = 8;
    localparam logic [7:0]  OP_MOVLW       = 8'h0E;
    localparam logic [7:0]  OP_MOVWF       = 8'h6E;
    localparam logic [7:0]  OP_MOVF        = 8'h50;
    localparam logic [7:0]  OP_BSF         = 8'h80;
    localparam logic [7:0]  OP_BCF         = 8'h90;
    localparam logic [7:0]  RAM_PTR_UPPER  = 8'hF8;
    localparam logic [7:0]  RAM_PTR_HIGH   = 8'hF7;
    localparam logic [7:0]  RAM_PTR_LOW    = 8'hF6;
    localparam logic [7:0]  RAM_TAB_LATCH  = 8'hF5;
    localparam logic [7:0]  RAM_MEM_CTRL   = 8'hA6;
    localparam logic [7:0]  RAM_EE_DATA    = 8'hA8;
    localparam logic [7:0]  RAM_EE_ADDR_LO = 8'hA9;
    localparam logic [7:0]  RAM_EE_ADDR_HI = 8'hAA;
    localparam int          CTRL_RD_BIT    = 0;
    localparam int          CTRL_CONFIG_SPACE_SELECT_BIT  = 6;
    localparam int          CTRL_PROGRAM_SPACE_SELECT_BIT = 7;
    localparam logic [21:0] CODE_LAST      = 22'h001FFF;
    localparam logic [21:0] ID_BASE        = 22'h200000;
    localparam logic [21:0] CFG_BASE       = 22'h300000;
    localparam logic [21:0] DEVID_LOW_ADDR = 22'h3FFFFE;
    localparam logic [21:0] DEVID_HI_ADDR  = 22'h3FFFFF;
    localparam logic [21:0] CFG5L_ADDR     = 22'h300008;
    localparam logic [21:0] CFG5H_ADDR     = 22'h300009;
    localparam logic [21:0] CFG6L_ADDR     = 22'h30000A;
    localparam logic [21:0] CFG6H_ADDR     = 22'h30000B;
    localparam logic [7:0]  CFG_RESET      = 8'hFF;
    localparam int          CONFIG_WRITE_PROTECT_BIT       = 5;
    // arbitrary neutral identity values
    localparam logic [7:0]  DEVID_HIGH_VAL = 8'h5A;
    localparam logic [2:0]  DEVID_VARIANT  = 3'h3;
    localparam logic [4:0]  DEVID_REV      = 5'h01;
endpackage
